// ### design/clo_pkg.sv
// Package with register map, field positions and reset values of the loop override bank
package clo_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] CLO_ADDR_START_CAP = 8'h08;
  localparam logic [7:0] CLO_ADDR_ENABLES   = 8'h09;
  localparam logic [7:0] CLO_ADDR_ENABLES_2 = 8'h0A;

  // ==========================================================================
  // Field widths
  // ==========================================================================
  localparam int CLO_CAP_W     = 5;
  localparam int CLO_LEVEL_W   = 5;
  localparam int CLO_PATH_W    = 3;
  localparam int CLO_DET_W     = 4;
  localparam int CLO_PUMP_PD_W = 2;
  localparam int CLO_DIV_W     = 3;
  localparam int CLO_IDAC_W    = 3;
  localparam int CLO_TRIP_W    = 8;

  // ==========================================================================
  // Bit positions in the first enable register
  // ==========================================================================
  localparam int CLO_B_CAP_FORCE   = 7;
  localparam int CLO_B_LEVEL_FORCE = 6;
  localparam int CLO_B_PATH_FORCE  = 5;
  localparam int CLO_B_DET_FORCE   = 4;
  localparam int CLO_B_PUMP_FORCE  = 3;
  localparam int CLO_B_DIV_FORCE   = 2;
  localparam int CLO_B_FLD_FORCE   = 1;
  localparam int CLO_B_KEEP_FD     = 0;

  // ==========================================================================
  // Bit positions in the second enable register
  // ==========================================================================
  localparam int CLO_B_SBT_FORCE   = 7;
  localparam int CLO_B_IDAC_FORCE  = 6;
  localparam int CLO_B_TRIP_FORCE  = 5;
  localparam int CLO_B_F150_FORCE  = 4;
  localparam int CLO_B_RST_FORCE   = 3;
  localparam int CLO_B_RST_VALUE   = 2;
  localparam int CLO_B_LOCK_FORCE  = 1;
  localparam int CLO_B_LOCK_VALUE  = 0;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [CLO_CAP_W-1:0] CLO_START_CAP_RESET = 5'h00;
  localparam logic [7:0]           CLO_ENABLES_RESET   = 8'h00;
  localparam logic [7:0]           CLO_ENABLES_2_RESET = 8'h10;
  localparam logic [7:0]           CLO_READ_ZERO       = 8'h00;

endpackage : clo_pkg

// ### design/clo_force_mux.sv
// Registered select between a forced value and an internal value from the lock state machine or the detector
`timescale 1ns/100ps

module clo_force_mux
  #(parameter int WIDTH = 1)
  (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             force_enable,
    input  wire logic [WIDTH-1:0] forced_value,
    input  wire logic [WIDTH-1:0] internal_value,
    output logic      [WIDTH-1:0] selected
  );

  // ==========================================================================
  // Select and register
  // ==========================================================================
  // Forced value wins only while its enable is set
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      selected <= '0;
    end
    else
    begin
      selected <= force_enable ? forced_value : internal_value;
    end
  end

endmodule // clo_force_mux

// ### design/clo_loop_override.sv
// Per-channel recovery loop override register bank and control selection
`timescale 1ns/100ps

// Operation
// [R1] The start capacitor field seeds the oscillator code and replaces the computed count when forced.
// [R2] A set filter level force drives the filter level from the supplied five-bit value.
// [R3] A set loopback force takes both loopthrough selects from the supplied three-bit value.
// [R4] A set detector force takes detector enable and the three power-downs from the supplied bits.
// [R5] A set pump power force takes both pump power-downs from the supplied two-bit value.
// [R6] A set divider force uses the supplied divider select, otherwise the normal choice applies.
// [R7] A set lock detector force takes its power-down from the supplied bit.
// [R8] With lock mode set and the detector force clear the frequency detector stays enabled while the loop is locked.
// [R9] A set single-bit force takes the single-bit transition enable from the supplied bit.
// [R10] A set current force takes both pump currents from the two supplied three-bit values.
// [R11] A set trip force takes the comparator trip voltages from the supplied eight-bit value.
// [R12] The 150 filter force resets to one and then takes that enable from the supplied bit.
// [R13] A set recovery reset force holds the loop in reset from the reset value bit.
// [R14] A set lock force reports lock from the lock value bit instead of the detector.
// [R15] A clear force leaves each control to the lock state machine, and lock indication to the detector, and ignores the value.
// [R16] The channel register reset restores all three registers to their defaults.
module clo_loop_override
  import clo_pkg::*;
  (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     channel_regs_reset,
    input  wire logic [7:0]               reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic [7:0]               reg_wdata,
    output logic      [7:0]               reg_rdata,
    input  wire logic [CLO_LEVEL_W-1:0]   filter_level_value,
    input  wire logic                     filter_150_value,
    input  wire logic [CLO_PATH_W-1:0]    loopback_path_value,
    input  wire logic [CLO_DET_W-1:0]     detector_power_value,
    input  wire logic [CLO_PUMP_PD_W-1:0] pump_power_value,
    input  wire logic [CLO_DIV_W-1:0]     divider_value,
    input  wire logic                     lock_detector_power_value,
    input  wire logic                     single_bit_value,
    input  wire logic [CLO_IDAC_W-1:0]    phase_pump_current_value,
    input  wire logic [CLO_IDAC_W-1:0]    freq_pump_current_value,
    input  wire logic [CLO_TRIP_W-1:0]    trip_value,
    input  wire logic [CLO_CAP_W-1:0]     sm_capacitor_count,
    input  wire logic [CLO_LEVEL_W-1:0]   sm_filter_level,
    input  wire logic                     sm_filter_150_enable,
    input  wire logic [CLO_PATH_W-1:0]    sm_loopback_path,
    input  wire logic [CLO_DET_W-1:0]     sm_detector_power,
    input  wire logic                     sm_locked,
    input  wire logic [CLO_PUMP_PD_W-1:0] sm_pump_power,
    input  wire logic [CLO_DIV_W-1:0]     sm_divider_select,
    input  wire logic                     sm_lock_detector_power,
    input  wire logic                     sm_single_bit_enable,
    input  wire logic [CLO_IDAC_W-1:0]    sm_phase_pump_current,
    input  wire logic [CLO_IDAC_W-1:0]    sm_freq_pump_current,
    input  wire logic [CLO_TRIP_W-1:0]    sm_trip_voltage,
    input  wire logic                     sm_recovery_reset,
    input  wire logic                     detector_lock,
    output logic      [CLO_CAP_W-1:0]     vco_initial_capacitor_code,
    output logic      [CLO_CAP_W-1:0]     capacitor_count,
    output logic      [CLO_LEVEL_W-1:0]   filter_level,
    output logic                          filter_150_enable,
    output logic      [CLO_PATH_W-1:0]    loopback_path,
    output logic      [CLO_DET_W-1:0]     detector_power,
    output logic      [CLO_PUMP_PD_W-1:0] pump_powerdown,
    output logic      [CLO_DIV_W-1:0]     divider_select,
    output logic                          freq_lock_detector_powerdown,
    output logic                          single_bit_enable,
    output logic      [CLO_IDAC_W-1:0]    phase_pump_current,
    output logic      [CLO_IDAC_W-1:0]    freq_pump_current,
    output logic      [CLO_TRIP_W-1:0]    trip_voltage,
    output logic                          recovery_reset,
    output logic                          lock_indication
  );

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [7:0] cdr_loop_override_enables;
  logic [7:0] cdr_loop_override_enables_2;
  logic       restore;
  logic       fd_internal;
  logic [CLO_DET_W-1:0] det_internal;

  assign restore = rst | channel_regs_reset;

  // Start capacitor code, upper bits reserved
  always_ff @(posedge clock)
  begin
    if (restore) // R16
    begin
      vco_initial_capacitor_code <= CLO_START_CAP_RESET;
    end
    else if (reg_wr && reg_addr == CLO_ADDR_START_CAP)
    begin
      vco_initial_capacitor_code <= reg_wdata[CLO_CAP_W-1:0]; // R1
    end
  end

  // First enable register
  always_ff @(posedge clock)
  begin
    if (restore) // R16
    begin
      cdr_loop_override_enables <= CLO_ENABLES_RESET;
    end
    else if (reg_wr && reg_addr == CLO_ADDR_ENABLES)
    begin
      cdr_loop_override_enables <= reg_wdata;
    end
  end

  // Second enable register, 150 filter force defaults high
  always_ff @(posedge clock)
  begin
    if (restore) // R12 R16
    begin
      cdr_loop_override_enables_2 <= CLO_ENABLES_2_RESET;
    end
    else if (reg_wr && reg_addr == CLO_ADDR_ENABLES_2)
    begin
      cdr_loop_override_enables_2 <= reg_wdata;
    end
  end

  // ==========================================================================
  // Read port
  // ==========================================================================
  // Registered read of the addressed register, zero elsewhere
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_rdata <= CLO_READ_ZERO;
    end
    else
    begin
      unique case (reg_addr)
        CLO_ADDR_START_CAP: reg_rdata <= {{(8-CLO_CAP_W){1'b0}}, vco_initial_capacitor_code};
        CLO_ADDR_ENABLES:   reg_rdata <= cdr_loop_override_enables;
        CLO_ADDR_ENABLES_2: reg_rdata <= cdr_loop_override_enables_2;
        default:            reg_rdata <= CLO_READ_ZERO;
      endcase
    end
  end

  // ==========================================================================
  // Control selection
  // ==========================================================================
  // Lock mode keeps the frequency detector on while locked
  assign fd_internal  = sm_detector_power[0] | (cdr_loop_override_enables[CLO_B_KEEP_FD] & sm_locked); // R8
  assign det_internal = {sm_detector_power[CLO_DET_W-1:1], fd_internal};

  // Each control takes its forced value only while enabled
  clo_force_mux #(.WIDTH(CLO_CAP_W)) u_cap ( // R1 R15
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables[CLO_B_CAP_FORCE]),
    .forced_value(vco_initial_capacitor_code), .internal_value(sm_capacitor_count), .selected(capacitor_count));
  clo_force_mux #(.WIDTH(CLO_LEVEL_W)) u_level ( // R2
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables[CLO_B_LEVEL_FORCE]),
    .forced_value(filter_level_value), .internal_value(sm_filter_level), .selected(filter_level));
  clo_force_mux #(.WIDTH(CLO_PATH_W)) u_path ( // R3
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables[CLO_B_PATH_FORCE]),
    .forced_value(loopback_path_value), .internal_value(sm_loopback_path), .selected(loopback_path));
  clo_force_mux #(.WIDTH(CLO_DET_W)) u_det ( // R4
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables[CLO_B_DET_FORCE]),
    .forced_value(detector_power_value), .internal_value(det_internal), .selected(detector_power));
  clo_force_mux #(.WIDTH(CLO_PUMP_PD_W)) u_pump ( // R5
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables[CLO_B_PUMP_FORCE]),
    .forced_value(pump_power_value), .internal_value(sm_pump_power), .selected(pump_powerdown));
  clo_force_mux #(.WIDTH(CLO_DIV_W)) u_div ( // R6
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables[CLO_B_DIV_FORCE]),
    .forced_value(divider_value), .internal_value(sm_divider_select), .selected(divider_select));
  clo_force_mux #(.WIDTH(1)) u_fld ( // R7
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables[CLO_B_FLD_FORCE]),
    .forced_value(lock_detector_power_value), .internal_value(sm_lock_detector_power),
    .selected(freq_lock_detector_powerdown));
  clo_force_mux #(.WIDTH(1)) u_sbt ( // R9
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables_2[CLO_B_SBT_FORCE]),
    .forced_value(single_bit_value), .internal_value(sm_single_bit_enable), .selected(single_bit_enable));
  clo_force_mux #(.WIDTH(2*CLO_IDAC_W)) u_idac ( // R10
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables_2[CLO_B_IDAC_FORCE]),
    .forced_value({phase_pump_current_value, freq_pump_current_value}),
    .internal_value({sm_phase_pump_current, sm_freq_pump_current}),
    .selected({phase_pump_current, freq_pump_current}));
  clo_force_mux #(.WIDTH(CLO_TRIP_W)) u_trip ( // R11
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables_2[CLO_B_TRIP_FORCE]),
    .forced_value(trip_value), .internal_value(sm_trip_voltage), .selected(trip_voltage));
  clo_force_mux #(.WIDTH(1)) u_f150 ( // R12
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables_2[CLO_B_F150_FORCE]),
    .forced_value(filter_150_value), .internal_value(sm_filter_150_enable), .selected(filter_150_enable));
  clo_force_mux #(.WIDTH(1)) u_rst ( // R13
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables_2[CLO_B_RST_FORCE]),
    .forced_value(cdr_loop_override_enables_2[CLO_B_RST_VALUE]), .internal_value(sm_recovery_reset),
    .selected(recovery_reset));
  clo_force_mux #(.WIDTH(1)) u_lock ( // R14
    .clock(clock), .rst(rst), .force_enable(cdr_loop_override_enables_2[CLO_B_LOCK_FORCE]),
    .forced_value(cdr_loop_override_enables_2[CLO_B_LOCK_VALUE]), .internal_value(detector_lock),
    .selected(lock_indication));

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_cap_force_select: assert property ( // R1
    $past(cdr_loop_override_enables[CLO_B_CAP_FORCE]) && !$past(rst)
      |-> capacitor_count == $past(vco_initial_capacitor_code))
    else $error("capacitor count not taken from start code");
  a_level_force_select: assert property ( // R2
    $past(cdr_loop_override_enables[CLO_B_LEVEL_FORCE]) && !$past(rst)
      |-> filter_level == $past(filter_level_value))
    else $error("filter level not forced");
  a_path_force_select: assert property ( // R3
    $past(cdr_loop_override_enables[CLO_B_PATH_FORCE]) && !$past(rst)
      |-> loopback_path == $past(loopback_path_value))
    else $error("loopback path not forced");
  a_fd_kept_locked: assert property ( // R8
    !$past(cdr_loop_override_enables[CLO_B_DET_FORCE]) && $past(cdr_loop_override_enables[CLO_B_KEEP_FD])
      && $past(sm_locked) && !$past(rst) |-> detector_power[0])
    else $error("frequency detector dropped while locked");
  a_div_normal_path: assert property ( // R6 R15
    !$past(cdr_loop_override_enables[CLO_B_DIV_FORCE]) && !$past(rst)
      |-> divider_select == $past(sm_divider_select))
    else $error("divider not from normal selection");
  a_reset_force_hold: assert property ( // R13
    (cdr_loop_override_enables_2[CLO_B_RST_FORCE] && cdr_loop_override_enables_2[CLO_B_RST_VALUE]
      && $stable(cdr_loop_override_enables_2)) [*2] |-> recovery_reset)
    else $error("recovery reset not held");
  a_lock_force_report: assert property ( // R14
    $past(cdr_loop_override_enables_2[CLO_B_LOCK_FORCE]) && !$past(rst)
      |-> lock_indication == $past(cdr_loop_override_enables_2[CLO_B_LOCK_VALUE]))
    else $error("lock indication not forced");
  a_trip_force_select: assert property ( // R11
    $past(cdr_loop_override_enables_2[CLO_B_TRIP_FORCE]) && !$past(rst)
      |-> trip_voltage == $past(trip_value))
    else $error("trip voltage not forced");
  a_regs_restore_all: assert property ( // R16 R12
    channel_regs_reset |=> cdr_loop_override_enables == CLO_ENABLES_RESET
      && cdr_loop_override_enables_2 == CLO_ENABLES_2_RESET && vco_initial_capacitor_code == CLO_START_CAP_RESET)
    else $error("channel reset did not restore defaults");
  a_write_read_back: assert property (
    reg_wr && reg_addr == CLO_ADDR_ENABLES && !channel_regs_reset ##1 !reg_wr && reg_addr == CLO_ADDR_ENABLES
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("enable register read back wrong");

  c_cap_forced:   cover property (cdr_loop_override_enables[CLO_B_CAP_FORCE] ##1 capacitor_count != sm_capacitor_count);
  c_lock_forced:  cover property (cdr_loop_override_enables_2[CLO_B_LOCK_FORCE] && !detector_lock ##1 lock_indication);
  c_keep_fd:      cover property (cdr_loop_override_enables[CLO_B_KEEP_FD] && sm_locked && !sm_detector_power[0]);
  c_chan_restore: cover property (cdr_loop_override_enables != CLO_ENABLES_RESET ##1 channel_regs_reset);

endmodule // clo_loop_override

// ### verification/clo_loop_override_test.sv
// Self-checking testbench for the recovery loop override register bank
`timescale 1ns/100ps

module clo_loop_override_test
  import clo_pkg::*;
  ();

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic                     clock, rst, channel_regs_reset, reg_wr, filter_150_value;
  logic                     lock_detector_power_value, single_bit_value, sm_filter_150_enable, sm_locked;
  logic                     sm_lock_detector_power, sm_single_bit_enable, sm_recovery_reset, detector_lock;
  logic                     filter_150_enable, freq_lock_detector_powerdown, single_bit_enable;
  logic                     recovery_reset, lock_indication;
  logic [7:0]               reg_addr, reg_wdata, reg_rdata, trip_value, sm_trip_voltage, trip_voltage;
  logic [CLO_CAP_W-1:0]     sm_capacitor_count, vco_initial_capacitor_code, capacitor_count;
  logic [CLO_LEVEL_W-1:0]   filter_level_value, sm_filter_level, filter_level;
  logic [CLO_PATH_W-1:0]    loopback_path_value, sm_loopback_path, loopback_path;
  logic [CLO_DET_W-1:0]     detector_power_value, sm_detector_power, detector_power;
  logic [CLO_PUMP_PD_W-1:0] pump_power_value, sm_pump_power, pump_powerdown;
  logic [CLO_DIV_W-1:0]     divider_value, sm_divider_select, divider_select;
  logic [CLO_IDAC_W-1:0]    phase_pump_current_value, freq_pump_current_value, sm_phase_pump_current;
  logic [CLO_IDAC_W-1:0]    sm_freq_pump_current, phase_pump_current, freq_pump_current;
  int                       fails;
  int                       comparisons;

  // ==========================================================================
  // Design under test
  // ==========================================================================
  clo_loop_override dut_u
  (
    .clock(clock), .rst(rst), .channel_regs_reset(channel_regs_reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .filter_level_value(filter_level_value), .filter_150_value(filter_150_value),
    .loopback_path_value(loopback_path_value), .detector_power_value(detector_power_value),
    .pump_power_value(pump_power_value), .divider_value(divider_value),
    .lock_detector_power_value(lock_detector_power_value), .single_bit_value(single_bit_value),
    .phase_pump_current_value(phase_pump_current_value), .freq_pump_current_value(freq_pump_current_value),
    .trip_value(trip_value), .sm_capacitor_count(sm_capacitor_count), .sm_filter_level(sm_filter_level),
    .sm_filter_150_enable(sm_filter_150_enable), .sm_loopback_path(sm_loopback_path),
    .sm_detector_power(sm_detector_power), .sm_locked(sm_locked), .sm_pump_power(sm_pump_power),
    .sm_divider_select(sm_divider_select), .sm_lock_detector_power(sm_lock_detector_power),
    .sm_single_bit_enable(sm_single_bit_enable), .sm_phase_pump_current(sm_phase_pump_current),
    .sm_freq_pump_current(sm_freq_pump_current), .sm_trip_voltage(sm_trip_voltage),
    .sm_recovery_reset(sm_recovery_reset), .detector_lock(detector_lock),
    .vco_initial_capacitor_code(vco_initial_capacitor_code), .capacitor_count(capacitor_count),
    .filter_level(filter_level), .filter_150_enable(filter_150_enable), .loopback_path(loopback_path),
    .detector_power(detector_power), .pump_powerdown(pump_powerdown), .divider_select(divider_select),
    .freq_lock_detector_powerdown(freq_lock_detector_powerdown), .single_bit_enable(single_bit_enable),
    .phase_pump_current(phase_pump_current), .freq_pump_current(freq_pump_current),
    .trip_voltage(trip_voltage), .recovery_reset(recovery_reset), .lock_indication(lock_indication)
  ); // clo_loop_override

  // Clock at 50 ns period
  always #25 clock = ~clock;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Compare one value, zero-extended to a byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One register write, taken at the edge that ends the task
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  // Present an address and compare the registered read data
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= addr;
    repeat (2) @(posedge clock);
    #1;
    chk(reg_rdata, exp);
  endtask

  // Let register and output stages update
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  // Check both enable registers and every control output against the selection
  task automatic check_outs(input logic [7:0] e1, input logic [7:0] e2, input logic [4:0] cap);
    rd(CLO_ADDR_ENABLES, e1);
    rd(CLO_ADDR_ENABLES_2, e2);
    chk(vco_initial_capacitor_code, cap);
    chk(capacitor_count, e1[7] ? cap : sm_capacitor_count);
    chk(filter_level, e1[6] ? filter_level_value : sm_filter_level);
    chk(loopback_path, e1[5] ? loopback_path_value : sm_loopback_path);
    chk(detector_power, e1[4] ? detector_power_value
                              : (sm_detector_power | {3'h0, e1[0] & sm_locked}));
    chk(pump_powerdown, e1[3] ? pump_power_value : sm_pump_power);
    chk(divider_select, e1[2] ? divider_value : sm_divider_select);
    chk(freq_lock_detector_powerdown, e1[1] ? lock_detector_power_value
                                            : sm_lock_detector_power);
    chk(single_bit_enable, e2[7] ? single_bit_value : sm_single_bit_enable);
    chk(phase_pump_current, e2[6] ? phase_pump_current_value : sm_phase_pump_current);
    chk(freq_pump_current, e2[6] ? freq_pump_current_value : sm_freq_pump_current);
    chk(trip_voltage, e2[5] ? trip_value : sm_trip_voltage);
    chk(filter_150_enable, e2[4] ? filter_150_value : sm_filter_150_enable);
    chk(recovery_reset, e2[3] ? e2[2] : sm_recovery_reset);
    chk(lock_indication, e2[1] ? e2[0] : detector_lock);
  endtask

  // Print the counts and the verdict, then end the run
  task automatic stop_test();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    clock = 1'b0;
    fails = 0;
    comparisons = 0;
    // Forced values and machine values differ in every bit
    rst <= 1'b1; channel_regs_reset <= 1'b0; reg_wr <= 1'b0; reg_addr <= 8'h00; reg_wdata <= 8'h00;
    filter_level_value <= 5'h15; filter_150_value <= 1'b0; loopback_path_value <= 3'h5;
    detector_power_value <= 4'hA; pump_power_value <= 2'h2; divider_value <= 3'h6;
    lock_detector_power_value <= 1'b1; single_bit_value <= 1'b1; phase_pump_current_value <= 3'h3;
    freq_pump_current_value <= 3'h4; trip_value <= 8'hA5; sm_capacitor_count <= 5'h0C;
    sm_filter_level <= 5'h0A; sm_filter_150_enable <= 1'b1; sm_loopback_path <= 3'h2;
    sm_detector_power <= 4'h5; sm_locked <= 1'b0; sm_pump_power <= 2'h1; sm_divider_select <= 3'h1;
    sm_lock_detector_power <= 1'b0; sm_single_bit_enable <= 1'b0; sm_phase_pump_current <= 3'h4;
    sm_freq_pump_current <= 3'h3; sm_trip_voltage <= 8'h5A; sm_recovery_reset <= 1'b1; detector_lock <= 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    settle();
    // Reset state, reserved start bits and an unmapped address
    rd(CLO_ADDR_START_CAP, 8'h00);
    check_outs(8'h00, 8'h10, 5'h00);
    wr(CLO_ADDR_START_CAP, 8'hF3);
    rd(CLO_ADDR_START_CAP, 8'h13);
    wr(8'h0B, 8'h55);
    rd(8'h0B, 8'h00);
    rd(CLO_ADDR_ENABLES, 8'h00);
    // Each bit of both enable registers set alone, the 150 filter force left high in the first pass
    for (int i = 0; i < 8; i++)
    begin
      wr(CLO_ADDR_ENABLES, 8'h01 << i);
      settle();
      check_outs(8'h01 << i, 8'h10, 5'h13);
    end
    wr(CLO_ADDR_ENABLES, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(CLO_ADDR_ENABLES_2, 8'h01 << i);
      settle();
      check_outs(8'h00, 8'h01 << i, 5'h13);
    end
    wr(CLO_ADDR_ENABLES, 8'hFE);
    wr(CLO_ADDR_ENABLES_2, 8'hFF);
    settle();
    check_outs(8'hFE, 8'hFF, 5'h13);
    // Lock mode keeps the frequency detector on only while locked
    wr(CLO_ADDR_ENABLES, 8'h01);
    wr(CLO_ADDR_ENABLES_2, 8'h0A);
    @(posedge clock);
    sm_detector_power <= 4'h4;
    sm_locked <= 1'b1;
    settle();
    check_outs(8'h01, 8'h0A, 5'h13);
    wr(CLO_ADDR_ENABLES, 8'h11);
    settle();
    check_outs(8'h11, 8'h0A, 5'h13);
    @(posedge clock);
    sm_locked <= 1'b0;
    wr(CLO_ADDR_ENABLES, 8'h01);
    settle();
    check_outs(8'h01, 8'h0A, 5'h13);
    // Channel register reset beats a same-edge write
    @(posedge clock);
    channel_regs_reset <= 1'b1;
    reg_addr <= CLO_ADDR_ENABLES;
    reg_wdata <= 8'hAA;
    reg_wr <= 1'b1;
    @(posedge clock);
    channel_regs_reset <= 1'b0;
    reg_wr <= 1'b0;
    settle();
    rd(CLO_ADDR_START_CAP, 8'h00);
    check_outs(8'h00, 8'h10, 5'h00);
    stop_test();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #(50 * 5000);
    fails++;
    stop_test();
  end

endmodule // clo_loop_override_test
